// >>> hdl/fskr_device.sv
// FSK receiver device end: demodulated-bit framing, serial port, event trigger.
// Assumes demodulated bits arrive from an analog front end on the clk_i domain;
// host pins on the link are asynchronous and are synchronised here.
// ----------------------------------------------------------------------
// Notes on behaviour
// [RL1] Mode pin low is mode 0, high mode 1
// [RL2] Mode 0 drives shift clock, mode 1 receives
// [RL3] Mode 0 shows each bit once demodulated
// [RL4] Mode 1 advances data on host rising edge
// [RL5] Power down stops all but event path
// [RL6] Demodulate only while enable is high
// [RL7] Host keeps enable low outside data
// [RL8] Event output rise delayed by RC interval
// [RL9] Event output flags reversal or ringing
// [RL10] 1200 baud, Bell 202 or V.23 data
// [RL11] Runs from 3.579545MHz timing reference; here a 10 MHz clk_i stands in for it
// [RL12] Mode 0 word ready pulses after eighth clock
// [RL13] Mode 1 word ready flags available word
// [RL14] Carrier output low while in-band signal present
// [RL15] Interrupt low while any source is active
// [RL16] Host gives eight clocks after word ready
module fskr_device #(
  parameter int unsigned RC_DELAY = fskr_pkg::RC_DELAY_DEF  // Event delay in cycles
) (
  input  wire logic clk_i,                 // 10 MHz clock standing in for the reference
  input  wire logic rst_b_i,               // Async reset, active low
  fskr_link_if.device link,                // Host side link
  input  wire logic demod_bit_i,           // Demodulated bit from front end
  input  wire logic demod_bit_valid_i,     // One-cycle strobe per demodulated bit
  input  wire logic in_band_i,             // In-band energy at bandpass output
  input  wire logic alert_detect_i,        // Guard-time qualified alert
  input  wire logic line_event_input_i     // Trigger input, async pin
);
  import fskr_pkg::*;
  // ----------------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] mode_s_reg;
  logic [1:0] pd_s_reg;
  logic [1:0] en_s_reg;
  logic [1:0] sclk_s_reg;
  logic [1:0] trig_s_reg;
  logic       sclk_prev_reg;
  // Two stages on every pin from the host or the line; each resets to the idle
  // level of its pin, so no false trigger follows reset. Power down resets high,
  // which keeps the device quiet until the host's level has been seen.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_s_reg    <= 2'h0;
      pd_s_reg      <= 2'h3;
      en_s_reg      <= 2'h0;
      sclk_s_reg    <= 2'h0;
      trig_s_reg    <= 2'h0;
      sclk_prev_reg <= 1'b0;
    end else begin
      mode_s_reg    <= {mode_s_reg[0], link.mode};
      pd_s_reg      <= {pd_s_reg[0], link.power_down_input};
      en_s_reg      <= {en_s_reg[0], link.demod_enable};
      sclk_s_reg    <= {sclk_s_reg[0], link.serial_shift_clock};
      trig_s_reg    <= {trig_s_reg[0], line_event_input_i};
      sclk_prev_reg <= sclk_s_reg[1];
    end
  end
  // Qualified levels and the host clock edge from synchronised pins; take_bit also gates in the unsynchronised bit strobe
  wire mode1     = mode_s_reg[1];                          // RL1
  wire pd        = pd_s_reg[1];
  wire active    = ~pd;                                    // RL5
  wire demod_on  = active & en_s_reg[1];                   // RL6
  wire take_bit  = demod_on & demod_bit_valid_i;           // RL10 RL11
  wire host_rise = mode1 & sclk_s_reg[1] & ~sclk_prev_reg; // RL4
  // ----------------------------------------------------------------------
  // Word assembly and serial output
  // ----------------------------------------------------------------------
  logic [7:0]      shift_reg;
  logic [7:0]      word_reg;
  logic [7:0]      out_reg;
  logic [3:0]      cnt_reg;
  logic [3:0]      hcnt_reg;
  logic            data_reg;
  logic            rdy_n_reg;
  logic            avail_reg;
  logic            sclk_reg;
  logic            sclk_oe_reg;
  logic [3:0]      half_reg;
  fskr_sclk_e      st_reg;
  // The last bit of a word is recognised in the cycle it is taken
  wire word_done = take_bit & (cnt_reg == 4'(WORD_BITS - 1));
  // Mode 0: each bit shows at once and a driven clock pulse starts in the same cycle.
  // A bit arriving inside a running pulse gets no pulse of its own.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shift_reg   <= WORD_RST;
      word_reg    <= WORD_RST;
      out_reg     <= WORD_RST;
      cnt_reg     <= BIT_CNT_RST;
      hcnt_reg    <= BIT_CNT_RST;
      data_reg    <= 1'b0;
      rdy_n_reg   <= 1'b1;
      avail_reg   <= 1'b0;
      sclk_reg    <= 1'b0;
      sclk_oe_reg <= 1'b0;
      half_reg    <= 4'h0;
      st_reg      <= FSKR_IDLE;
    end else if (!active) begin
      // Power down drops a half-built word and releases the clock pin
      cnt_reg     <= BIT_CNT_RST;
      rdy_n_reg   <= 1'b1;
      avail_reg   <= 1'b0;
      sclk_reg    <= 1'b0;
      sclk_oe_reg <= 1'b0;
      st_reg      <= FSKR_IDLE;
    end else begin
      sclk_oe_reg <= ~mode1;                               // RL2
      if (take_bit) begin
        // LSB first, entering at the top of the shift register
        shift_reg <= {demod_bit_i, shift_reg[7:1]};
        cnt_reg   <= word_done ? BIT_CNT_RST : cnt_reg + 4'h1;
        if (!mode1) data_reg <= demod_bit_i;               // RL3
      end
      if (word_done) begin
        word_reg <= {demod_bit_i, shift_reg[7:1]};
        // Mode 1: the whole word waits for the host clock, bit 0 shown at once
        if (mode1) begin
          out_reg   <= {demod_bit_i, shift_reg[7:1]};
          data_reg  <= shift_reg[1];
          hcnt_reg  <= BIT_CNT_RST;
          avail_reg <= 1'b1;
          rdy_n_reg <= 1'b0;                               // RL13
        end
      end
      // Host-clocked shift-out, LSB first, first bit already presented
      if (host_rise && avail_reg) begin
        rdy_n_reg <= 1'b1;
        hcnt_reg  <= hcnt_reg + 4'h1;
        out_reg   <= {1'b0, out_reg[7:1]};
        data_reg  <= out_reg[1];                           // RL4
        if (hcnt_reg == 4'(WORD_BITS - 1)) avail_reg <= 1'b0;
      end
      case (st_reg)
        FSKR_IDLE: begin
          if (take_bit && !mode1) begin
            st_reg   <= FSKR_HIGH;
            sclk_reg <= 1'b1;
            half_reg <= 4'h0;
          end
        end
        FSKR_HIGH: begin
          half_reg <= half_reg + 4'h1;
          if (half_reg == 4'(SCLK_HALF_CYC - 1)) begin
            sclk_reg <= 1'b0;
            st_reg   <= FSKR_LOW;
            half_reg <= 4'h0;
            if (cnt_reg == BIT_CNT_RST) rdy_n_reg <= 1'b0; // RL12
          end
        end
        FSKR_LOW: begin
          half_reg <= half_reg + 4'h1;
          if (half_reg == 4'(SCLK_HALF_CYC - 1)) begin
            st_reg <= FSKR_IDLE;
            // Word ready ends with the low phase of the last pulse
            if (!mode1) rdy_n_reg <= 1'b1;
          end
        end
        default: st_reg <= FSKR_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------------
  // Line event path, alive in power down
  // ----------------------------------------------------------------------
  logic [31:0] rc_reg;
  logic        evt_reg;
  logic        car_n_reg;
  logic        alert_reg;
  // High on the trigger input holds the node discharged and the output low; once
  // it falls the output rises after the delay. The counter stands in for the
  // external network, so the interval is set by RC_DELAY, not by board parts.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rc_reg    <= 32'h0;
      evt_reg   <= 1'b1;
      car_n_reg <= 1'b1;
      alert_reg <= 1'b0;
    end else begin
      if (trig_s_reg[1]) begin
        rc_reg  <= 32'h0;
        evt_reg <= 1'b0;                                   // RL9
      end else if (rc_reg < RC_DELAY) begin
        rc_reg <= rc_reg + 32'h1;
      end else begin
        evt_reg <= 1'b1;                                   // RL8
      end
      // Carrier and alert follow their sources only while powered up
      car_n_reg <= ~(active & in_band_i);                  // RL14
      alert_reg <= active & alert_detect_i;
    end
  end
  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Every pin comes from a flip-flop; only the interrupt pull is combined
  assign link.sclk_dev_o           = sclk_reg;
  assign link.sclk_dev_oe          = sclk_oe_reg;
  assign link.serial_data          = data_reg;
  assign link.word_ready_n         = rdy_n_reg;
  assign link.carrier_present_n    = car_n_reg;
  assign link.line_event_detect    = evt_reg;
  assign link.alert_tone_qualified = alert_reg;
  assign link.int_n_oe             = ~evt_reg | ~rdy_n_reg | alert_reg; // RL15
endmodule

// >>> hdl/fskr_host.sv
// Host controller end: drives mode, power down and enable, collects words.
// Software reaches it over a plain port; link inputs are synchronised here.
module fskr_host (
  input  wire logic        clk_i,      // 10 MHz clock
  input  wire logic        rst_b_i,    // Async reset, active low
  fskr_link_if.host        link,       // Device side link
  input  wire logic [3:0]  addr_i,     // Byte address
  input  wire logic [31:0] wdata_i,    // Write data
  input  wire logic        wr_i,       // Write strobe
  input  wire logic        rd_i,       // Read strobe
  output logic      [31:0] rdata_o,    // Read data, cycle after strobe
  output logic             irq_o       // Level interrupt
);
  import fskr_pkg::*;
  // ----------------------------------------------------------------------
  // Sync and registers
  // ----------------------------------------------------------------------
  logic [1:0] clk_s_reg, dat_s_reg, rdy_s_reg, evt_s_reg, alt_s_reg;
  logic       clk_prev_reg, rdy_prev_reg, evt_prev_reg, alt_prev_reg;
  logic [2:0] ctrl_reg, mask_reg, stat_reg;
  logic [7:0] sh_reg, word_reg;
  logic [3:0] cnt_reg, half_reg;
  logic       sclk_reg, busy_reg;
  logic [31:0] rdata_reg;
  wire mode1    = ctrl_reg[0];
  wire m0_rise  = ~mode1 & clk_s_reg[1] & ~clk_prev_reg;
  wire rdy_fall = ~rdy_s_reg[1] & rdy_prev_reg;
  wire evt_fall = ~evt_s_reg[1] & evt_prev_reg;
  wire alt_rise = alt_s_reg[1] & ~alt_prev_reg;
  wire sample   = busy_reg & sclk_reg & (half_reg == 4'(SCLK_HALF_CYC - 1)); // RL16
  wire last     = sample & (cnt_reg == 4'(WORD_BITS - 1));
  wire got_word = (~mode1 & rdy_fall) | last;
  wire [2:0] ev = {alt_rise, evt_fall, got_word};
  wire [2:0] clr = (wr_i && addr_i == REG_STATUS) ? wdata_i[2:0] : 3'h0;
  // Synchronisers and edge history
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clk_s_reg    <= 2'h0;
      dat_s_reg    <= 2'h0;
      rdy_s_reg    <= 2'h3;
      evt_s_reg    <= 2'h3;
      alt_s_reg    <= 2'h0;
      clk_prev_reg <= 1'b0;
      rdy_prev_reg <= 1'b1;
      evt_prev_reg <= 1'b1;
      alt_prev_reg <= 1'b0;
    end else begin
      clk_s_reg <= {clk_s_reg[0], link.serial_shift_clock};
      dat_s_reg <= {dat_s_reg[0], link.serial_data};
      rdy_s_reg <= {rdy_s_reg[0], link.word_ready_n};
      evt_s_reg <= {evt_s_reg[0], link.line_event_detect};
      alt_s_reg <= {alt_s_reg[0], link.alert_tone_qualified};
      clk_prev_reg <= clk_s_reg[1];
      rdy_prev_reg <= rdy_s_reg[1];
      evt_prev_reg <= evt_s_reg[1];
      alt_prev_reg <= alt_s_reg[1];
    end
  end
  // Register file and word capture; events win over a clear
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_reg  <= CTRL_RST;
      mask_reg  <= MASK_RST;
      stat_reg  <= 3'h0;
      sh_reg    <= WORD_RST;
      word_reg  <= WORD_RST;
      rdata_reg <= 32'h0;
    end else begin
      if (wr_i && addr_i == REG_CTRL) ctrl_reg <= wdata_i[2:0];  // RL1 RL5 RL6 RL7
      if (wr_i && addr_i == REG_MASK) mask_reg <= wdata_i[2:0];
      stat_reg <= (stat_reg & ~clr) | ev;
      if (m0_rise || sample) sh_reg <= {dat_s_reg[1], sh_reg[7:1]};
      if (last) word_reg <= {dat_s_reg[1], sh_reg[7:1]};
      else if (~mode1 & rdy_fall) word_reg <= sh_reg;
      rdata_reg <= 32'h0;
      if (rd_i) begin
        case (addr_i)
          REG_CTRL:   rdata_reg <= {29'h0, ctrl_reg};
          REG_STATUS: rdata_reg <= {29'h0, stat_reg};
          REG_MASK:   rdata_reg <= {29'h0, mask_reg};
          REG_DATA:   rdata_reg <= {24'h0, word_reg};
          default:    rdata_reg <= 32'h0;
        endcase
      end
    end
  end
  // Mode 1 clock generator: eight pulses only after word ready falls
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_reg <= 1'b0;
      sclk_reg <= 1'b0;
      cnt_reg  <= 4'h0;
      half_reg <= 4'h0;
    end else if (!busy_reg) begin
      sclk_reg <= 1'b0;
      if (mode1 && rdy_fall) begin
        busy_reg <= 1'b1;                                  // RL16
        cnt_reg  <= 4'h0;
        half_reg <= 4'h0;
      end
    end else begin
      half_reg <= half_reg + 4'h1;
      if (half_reg == 4'(SCLK_HALF_CYC - 1)) begin
        half_reg <= 4'h0;
        sclk_reg <= ~sclk_reg;
        if (sclk_reg) begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == 4'(WORD_BITS - 1)) busy_reg <= 1'b0;
        end
      end
    end
  end
  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign link.mode             = ctrl_reg[0];
  assign link.power_down_input = ctrl_reg[1];
  assign link.demod_enable     = ctrl_reg[2];
  assign link.sclk_host_o      = sclk_reg;
  assign link.sclk_host_oe     = mode1;   // RL2
  assign rdata_o               = rdata_reg;
  assign irq_o                 = |(stat_reg & mask_reg);
endmodule

// >>> hdl/fskr_link_if.sv
// Interface joining the FSK receiver device and its host controller.
// The shift clock is two-way: the interface resolves the wire from both enables.
interface fskr_link_if;
  logic mode;                 // Interface mode select, from host
  logic power_down_input;     // Power down, from host
  logic demod_enable;         // Demodulator enable, from host
  logic sclk_dev_o, sclk_dev_oe;
  logic sclk_host_o, sclk_host_oe;
  logic serial_shift_clock;   // Resolved wire level
  logic serial_data;
  logic word_ready_n;
  logic carrier_present_n;
  logic line_event_detect;
  logic alert_tone_qualified;
  logic int_n_oe;             // Open drain interrupt, low while driven
  logic int_n;
  // ----------------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------------
  assign serial_shift_clock = sclk_dev_oe ? sclk_dev_o : (sclk_host_oe ? sclk_host_o : 1'b0);
  assign int_n              = ~int_n_oe;
  modport device (input mode, power_down_input, demod_enable, serial_shift_clock,
                  output sclk_dev_o, sclk_dev_oe, serial_data, word_ready_n,
                  carrier_present_n, line_event_detect, alert_tone_qualified, int_n_oe);
  modport host (input serial_shift_clock, serial_data, word_ready_n, carrier_present_n,
                line_event_detect, alert_tone_qualified, int_n,
                output mode, power_down_input, demod_enable, sclk_host_o, sclk_host_oe);
endinterface

// >>> hdl/fskr_pkg.sv
// Package for the FSK receiver serial port: shared constants and types.
// Assumes a 10 MHz system clock on both ends; no register bus on the device.
package fskr_pkg;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned BAUD            = 1200;
  localparam int unsigned BIT_CYCLES      = CLK_HZ / BAUD;      // Cycles per demodulated bit
  localparam int unsigned SCLK_HALF_NS    = 400;                // Half period of a driven shift clock
  localparam int unsigned CLK_NS          = 100;
  localparam int unsigned SCLK_HALF_CYC   = SCLK_HALF_NS / CLK_NS;
  localparam int unsigned WORD_BITS       = 8;
  localparam int unsigned RC_DELAY_DEF    = 2000;               // Default event delay in cycles
  localparam logic [3:0]  BIT_CNT_RST     = 4'h0;
  localparam logic [7:0]  WORD_RST        = 8'h00;
  // ----------------------------------------------------------------------
  // Host register map (word index = byte address / 4)
  // ----------------------------------------------------------------------
  localparam logic [3:0]  REG_CTRL        = 4'h0;  // [0] mode,[1] power down,[2] demod enable
  localparam logic [3:0]  REG_STATUS      = 4'h4;  // Sticky events, write one to clear
  localparam logic [3:0]  REG_MASK        = 4'h8;
  localparam logic [3:0]  REG_DATA        = 4'hC;  // Last received word
  localparam logic [2:0]  CTRL_RST        = 3'h0;
  localparam logic [2:0]  MASK_RST        = 3'h0;
  // Status bits
  localparam int unsigned ST_WORD         = 0;
  localparam int unsigned ST_EVENT        = 1;
  localparam int unsigned ST_ALERT        = 2;
  typedef enum logic [1:0] {FSKR_IDLE, FSKR_HIGH, FSKR_LOW} fskr_sclk_e;
endpackage

// >>> verification/fskr_link_chk.sv
// Checker for the FSK receiver link: assertions on the interface wires.
// Assumes both ends share clk_i and rst_b_i; tb_top instantiates it.
module fskr_link_chk #(
  parameter int unsigned RC_DELAY = fskr_pkg::RC_DELAY_DEF  // Event delay in cycles
) (
  input wire logic clk_i,                // Clock
  input wire logic rst_b_i,              // Reset, active low
  input wire logic mode,                 // Mode select
  input wire logic power_down_input,     // Power down
  input wire logic sclk_dev_o,           // Device clock out
  input wire logic sclk_dev_oe,          // Device clock enable
  input wire logic sclk_host_oe,         // Host clock enable
  input wire logic serial_shift_clock,   // Resolved clock wire
  input wire logic serial_data,          // Data wire
  input wire logic word_ready_n,         // Word ready
  input wire logic line_event_detect,    // Event output
  input wire logic alert_tone_qualified, // Alert output
  input wire logic int_n_oe              // Interrupt pull
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // --------------------------------------------------------------------
  // Helper: cycles the event output has been low
  // --------------------------------------------------------------------
  logic [15:0] low_cnt_reg;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_cnt_reg <= 16'h0000;
    end else if (line_event_detect) begin
      low_cnt_reg <= 16'h0000;
    end else begin
      low_cnt_reg <= low_cnt_reg + 16'h0001;
    end
  end
  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  property p_int_src;
    int_n_oe == (!line_event_detect || !word_ready_n || alert_tone_qualified);
  endproperty
  a_int_src: assert property (p_int_src) else $error("interrupt pull wrong");
  property p_host_oe;
    !mode [*4] |-> !sclk_host_oe && (serial_shift_clock == sclk_dev_o);
  endproperty
  a_host_oe: assert property (p_host_oe) else $error("shift clock not device driven in mode 0");
  property p_dev_oe;
    mode [*4] |-> !sclk_dev_oe;
  endproperty
  a_dev_oe: assert property (p_dev_oe) else $error("device drives clock in mode 1");
  property p_dev_high;
    $rose(sclk_dev_o) |-> sclk_dev_o [*4] ##1 !sclk_dev_o;
  endproperty
  a_dev_high: assert property (p_dev_high) else $error("clock high phase wrong");
  property p_data_hold;
    !mode && sclk_dev_o && $past(sclk_dev_o) |-> $stable(serial_data);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved in high phase");
  property p_ready_m0;
    !mode && $fell(word_ready_n) |-> !word_ready_n [*4] ##1 word_ready_n;
  endproperty
  a_ready_m0: assert property (p_ready_m0) else $error("mode 0 ready pulse wrong");
  property p_ready_m1;
    mode && !word_ready_n && $rose(serial_shift_clock) |-> ##[1:4] word_ready_n;
  endproperty
  a_ready_m1: assert property (p_ready_m1) else $error("mode 1 ready not released");
  property p_pd;
    power_down_input [*5] |-> word_ready_n && !sclk_dev_oe;
  endproperty
  a_pd: assert property (p_pd) else $error("activity in power down");
  property p_event;
    $rose(line_event_detect) |-> low_cnt_reg >= 16'(RC_DELAY + 1);
  endproperty
  a_event: assert property (p_event) else $error("event output rose early");
endmodule

// >>> verification/tb_top.sv
// Testbench: device and host ends joined by the link interface.
// Assumes the host register map of fskr_pkg; reads are checked from a queue.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fskr_pkg::*;
  localparam int unsigned RC     = 20;    // Short event delay
  localparam int unsigned WD_CYC = 6000;  // Tests need about 700 cycles
  logic        clk_i, rst_b_i, demod_bit_i, demod_bit_valid_i;
  logic        in_band_i, alert_detect_i, line_event_input_i;
  logic        wr_i, rd_i, rd_d, irq_o;
  logic [3:0]  addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [31:0] exp_q[$];
  logic [7:0]  byte_v;
  int          mismatches, tests_run;
  fskr_link_if link ();
  fskr_device #(.RC_DELAY(RC)) u_fskr_device (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link),
    .demod_bit_i(demod_bit_i), .demod_bit_valid_i(demod_bit_valid_i), .in_band_i(in_band_i),
    .alert_detect_i(alert_detect_i), .line_event_input_i(line_event_input_i));
  fskr_host u_fskr_host (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
  fskr_link_chk #(.RC_DELAY(RC)) u_fskr_link_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .mode(link.mode), .power_down_input(link.power_down_input), .sclk_dev_o(link.sclk_dev_o),
    .sclk_dev_oe(link.sclk_dev_oe), .sclk_host_oe(link.sclk_host_oe),
    .serial_shift_clock(link.serial_shift_clock), .serial_data(link.serial_data),
    .word_ready_n(link.word_ready_n), .line_event_detect(link.line_event_detect),
    .alert_tone_qualified(link.alert_tone_qualified), .int_n_oe(link.int_n_oe));
  // --------------------------------------------------------------------
  // Compare, bus and stimulus tasks
  // --------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkb(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  // Idle cycles; both strobes drop here, and each transfer drops the other kind's, so back-to-back transfers of one kind hold theirs
  task automatic cyc(input int n);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    rd_i    <= 1'b0;
    @(posedge clk_i);
  endtask
  // The expected word is queued here and checked by the monitor
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    addr_i <= a;
    rd_i   <= 1'b1;
    wr_i   <= 1'b0;
    @(posedge clk_i);
  endtask
  // Bits spaced 12 cycles: above the minimum, far below real baud to keep runs short
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      demod_bit_i       <= b[i];
      demod_bit_valid_i <= 1'b1;
      @(posedge clk_i);
      demod_bit_valid_i <= 1'b0;
      cyc(11);
    end
  endtask
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // --------------------------------------------------------------------
  // Clock, read monitor and watchdog
  // --------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (rd_d) chk("rdata", exp_q.pop_front(), rdata_o);
    rd_d <= rd_i;
  end
  initial begin
    #(WD_CYC * 100);
    mismatches++;
    conclude();
  end
  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    {rst_b_i, demod_bit_i, demod_bit_valid_i, in_band_i, alert_detect_i} = 5'h00;
    {line_event_input_i, wr_i, rd_i} = 3'h0;
    addr_i = 4'h0;
    wdata_i = 32'h0;
    mismatches = 0;
    tests_run = 0;
    byte_v = 8'($urandom(32'h3072edae));
    cyc(4);
    rst_b_i <= 1'b1;
    rd(REG_CTRL, 32'h0);
    rd(REG_STATUS, 32'h0);
    rd(4'h2, 32'h0);
    chkb("ready", 1'b1, link.word_ready_n);
    chkb("int", 1'b1, link.int_n);
    done("reset");
    wr(REG_MASK, 32'h7);
    wr(REG_CTRL, 32'h4);
    cyc(6);
    send(byte_v);
    cyc(20);
    rd(REG_DATA, {24'h0, byte_v});
    rd(REG_STATUS, 32'h1);
    chkb("irq", 1'b1, irq_o);
    wr(REG_STATUS, 32'h1);
    rd(REG_STATUS, 32'h0);
    done("mode0");
    // Demod off, then powered down: bits must be ignored
    for (int k = 0; k < 2; k++) begin
      wr(REG_CTRL, (k == 1) ? 32'h6 : 32'h0);
      cyc(6);
      send(~byte_v);
      cyc(20);
      rd(REG_DATA, {24'h0, byte_v});
      rd(REG_STATUS, 32'h0);
    end
    // Still powered down: the event path stays alive
    line_event_input_i <= 1'b1;
    cyc(6);
    chkb("event", 1'b0, link.line_event_detect);
    chkb("int", 1'b0, link.int_n);
    line_event_input_i <= 1'b0;
    cyc(RC - 1);
    chkb("event", 1'b0, link.line_event_detect);
    cyc(10);
    chkb("event", 1'b1, link.line_event_detect);
    rd(REG_STATUS, 32'h2);
    wr(REG_STATUS, 32'h2);
    done("event");
    wr(REG_CTRL, 32'h4);
    alert_detect_i <= 1'b1;
    in_band_i <= 1'b1;
    cyc(6);
    chkb("alert", 1'b1, link.alert_tone_qualified);
    chkb("carrier", 1'b0, link.carrier_present_n);
    chkb("int", 1'b0, link.int_n);
    rd(REG_STATUS, 32'h4);
    alert_detect_i <= 1'b0;
    in_band_i <= 1'b0;
    wr(REG_MASK, 32'h0);
    cyc(6);
    chkb("carrier", 1'b1, link.carrier_present_n);
    chkb("int", 1'b1, link.int_n);
    chkb("irq", 1'b0, irq_o);
    wr(REG_STATUS, 32'h7);
    rd(REG_STATUS, 32'h0);
    done("alert");
    byte_v = 8'($urandom());
    wr(REG_CTRL, 32'h5);
    cyc(6);
    send(byte_v);
    cyc(150);
    rd(REG_DATA, {24'h0, byte_v});
    rd(REG_STATUS, 32'h1);
    cyc(2);
    done("mode1");
    conclude();
  end
endmodule
